// >>> design/dacsp_pkg.sv
// Shared constants for the converter two-wire slave with power-down
`default_nettype none
package dacsp_pkg;
    // Clock and wake-up timing
    localparam int CLK_MHZ = 40;
    localparam int WAKE_NS = 800;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    // Three-level address-select pin encoding
    localparam logic [1:0] PIN_GND = 2'h0;
    localparam logic [1:0] PIN_FLOAT = 2'h1;
    localparam logic [1:0] PIN_SUPPLY = 2'h2;
    // Slave address bases by upper pin level, offsets by lower pin level
    localparam logic [6:0] BASE_HI_FLOAT = 7'h0C;
    localparam logic [6:0] BASE_HI_GND = 7'h08;
    localparam logic [6:0] BASE_HI_SUPPLY = 7'h4C;
    localparam logic [6:0] OFS_LO_FLOAT = 7'h00;
    localparam logic [6:0] OFS_LO_GND = 7'h01;
    localparam logic [6:0] OFS_LO_SUPPLY = 7'h02;
    localparam logic [6:0] BCAST_ADDR = 7'h48;
    localparam logic [4:0] MCODE_PFX = 5'h01;
    // Converter register layout
    localparam int REG_MODE_HI = 13;
    localparam int REG_MODE_LO = 12;
    localparam int REG_CODE_HI = 11;
    localparam int REG_CODE_LO = 2;
    localparam logic [15:0] REG_RST = 16'h0000;
    // Register bus map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_WORD = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_HS_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_ADDR_LO = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum {
        S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK, S_IGN
    } dacsp_state_t;
endpackage
`default_nettype wire

// >>> design/dacsp_top.sv
// Two-wire slave, converter register and power-down control
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
// Notes on behaviour
// - Either mode bit set puts the device in power-down; both zero is normal
// - Mode field picks high impedance, 2.5k or 100k termination
// - Register, mode bits included, is kept in power-down and reads back
// - A write leaving power-down replaces the register and output code
// - Output becomes valid only after a fixed wake-up delay
// - Zero is sent by pulling low, one by releasing the line
// - Address byte is acknowledged only when the address matches
// - Every received write data byte is acknowledged
// - Start is data falling while clock high; transactions begin there
// - Stop is data rising while clock high; bus idles afterwards
// - Repeated start takes a fresh address and keeps the speed mode
// - Seven address bits and a direction bit precede the ack slot
// - Write takes upper then lower byte, each acked, then updates
// - Further byte pairs keep updating the register until a stop
// - Read sends upper byte, waits for ack, then sends lower byte
// - Master code 00001XXX is not acknowledged and enters high speed
// - High speed persists over repeated starts and ends at a stop
// - Own address comes from the three-level select pins
// - Broadcast address 1001000 is accepted for writes
// - Select pins are locked after the first own-address match
// - Direction bit one selects a read after an acked address
// - Register clears to zero at power-up, output held at zero
// - Register is two zero bits, two mode bits, ten data bits, two low bits
// - Output updates at the rising clock of the lower byte ack
module dacsp_top
    import dacsp_pkg::*;
#(
    parameter int AXI_AW = 8,
    parameter int WAKE_CYCLES = WAKE_CYC
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus write
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Register bus read
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Address-select pins, three-level coded
    input wire logic [1:0] addr_select_pin_lo,
    input wire logic [1:0] addr_select_pin_hi,
    // Converter side
    output logic [9:0] dac_code,
    output logic powerdown_sel_hi,
    output logic powerdown_sel_lo,
    output logic powerdown,
    output logic out_valid
);
    localparam int CW = $clog2(WAKE_CYCLES + 1);

    if (WAKE_CYCLES < 1 || AXI_AW < 4)
    begin : g_chk
        $error("dacsp_top: unsupported parameter value");
    end

    logic scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
    logic [1:0] lo_m_q, lo_s_q, hi_m_q, hi_s_q;
    dacsp_state_t st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q, hi_q, tx_q;
    logic hit_q, rw_q, lo_q, hs_q, drv_q, lock_q, en_q;
    logic [6:0] lock_addr_q, base, ofs, pin_addr, own_addr;
    logic [15:0] reg_q;
    logic [9:0] code_q;
    logic [1:0] mode_q;
    logic valid_q;
    logic [CW-1:0] wake_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Pins are asynchronous to aclk
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {scl_m_q, scl_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_q, sda_p_q} <= 3'h7;
            {lo_m_q, lo_s_q, hi_m_q, hi_s_q} <= 8'h55;
        end
        else
        begin
            scl_m_q <= scl_i;
            scl_q <= scl_m_q;
            scl_p_q <= scl_q;
            sda_m_q <= sda_i;
            sda_q <= sda_m_q;
            sda_p_q <= sda_q;
            lo_m_q <= addr_select_pin_lo;
            lo_s_q <= lo_m_q;
            hi_m_q <= addr_select_pin_hi;
            hi_s_q <= hi_m_q;
        end
    end

    wire scl_rise = scl_q & ~scl_p_q;
    wire scl_fall = ~scl_q & scl_p_q;
    wire start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
    wire stop_det = scl_q & scl_p_q & ~sda_p_q & sda_q;

    always_comb
    begin
        case (hi_s_q)
            PIN_GND: base = BASE_HI_GND;
            PIN_SUPPLY: base = BASE_HI_SUPPLY;
            default: base = BASE_HI_FLOAT;
        endcase
        case (lo_s_q)
            PIN_GND: ofs = OFS_LO_GND;
            PIN_SUPPLY: ofs = OFS_LO_SUPPLY;
            default: ofs = OFS_LO_FLOAT;
        endcase
        pin_addr = base + ofs;
        own_addr = lock_q ? lock_addr_q : pin_addr;
    end

    wire [7:0] rx_byte = {sh_q[6:0], sda_q};
    wire addr_last = scl_rise && st_q == S_ADDR && bit_q == 3'h7;
    wire own_hit = en_q && rx_byte[7:1] == own_addr;
    // Broadcast reads would collide between devices, so only writes pass
    wire bc_hit = en_q && rx_byte[7:1] == BCAST_ADDR && !rx_byte[0];
    wire mcode = rx_byte[7:3] == MCODE_PFX;
    wire commit = scl_rise && st_q == S_WACK && lo_q;
    wire [15:0] new_word = {2'b00, hi_q[5:0], sh_q};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= S_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            hit_q <= 1'b0;
            rw_q <= 1'b0;
            lo_q <= 1'b0;
            hs_q <= 1'b0;
        end
        else if (stop_det)
        begin
            st_q <= S_IDLE;
            hs_q <= 1'b0;
        end
        else if (start_det)
        begin
            st_q <= S_ADDR;
            bit_q <= 3'h0;
        end
        else if (scl_rise)
        begin
            case (st_q)
                S_ADDR:
                begin
                    sh_q <= rx_byte;
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7)
                    begin
                        st_q <= S_AACK;
                        hit_q <= own_hit | bc_hit;
                        rw_q <= rx_byte[0];
                        if (mcode)
                            hs_q <= 1'b1;
                    end
                end
                S_AACK:
                begin
                    bit_q <= 3'h0;
                    lo_q <= 1'b0;
                    if (!hit_q)
                        st_q <= S_IGN;
                    else if (rw_q)
                        st_q <= S_RD;
                    else
                        st_q <= S_WR;
                end
                S_WR:
                begin
                    sh_q <= rx_byte;
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7)
                        st_q <= S_WACK;
                end
                S_WACK:
                begin
                    st_q <= S_WR;
                    lo_q <= ~lo_q;
                    bit_q <= 3'h0;
                end
                S_RD:
                begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7)
                        st_q <= S_RACK;
                end
                S_RACK:
                begin
                    bit_q <= 3'h0;
                    if (!sda_q && !lo_q)
                    begin
                        st_q <= S_RD;
                        lo_q <= 1'b1;
                    end
                    else
                        st_q <= S_IGN;
                end
                default: st_q <= st_q;
            endcase
        end
    end

    // Upper write byte is held until its partner arrives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hi_q <= 8'h00;
        else if (scl_rise && st_q == S_WACK && !lo_q)
            hi_q <= sh_q;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_q <= 8'h00;
        else if (scl_rise && st_q == S_AACK && hit_q && rw_q)
            tx_q <= reg_q[15:8];
        else if (scl_rise && st_q == S_RACK && !sda_q)
            tx_q <= reg_q[7:0];
        else if (scl_rise && st_q == S_RD)
            tx_q <= {tx_q[6:0], 1'b0};
    end

    // Data changes only after clock falls, so no false start or stop
    always_ff @(posedge aclk)
    begin
        if (!aresetn || start_det || stop_det)
            drv_q <= 1'b0;
        else if (scl_fall)
            drv_q <= (st_q == S_AACK && hit_q) || st_q == S_WACK
                || (st_q == S_RD && !tx_q[7]);
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = ~drv_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_q <= 1'b0;
            lock_addr_q <= 7'h00;
        end
        else if (addr_last && own_hit && !lock_q)
        begin
            lock_q <= 1'b1;
            lock_addr_q <= pin_addr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reg_q <= REG_RST;
            code_q <= 10'h000;
            mode_q <= 2'h0;
        end
        else if (commit)
        begin
            reg_q <= new_word;
            code_q <= new_word[REG_CODE_HI:REG_CODE_LO];
            mode_q <= new_word[REG_MODE_HI:REG_MODE_LO];
        end
    end

    wire pd_exit = commit && mode_q != 2'h0
        && new_word[REG_MODE_HI:REG_MODE_LO] == 2'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            valid_q <= 1'b1;
            wake_q <= '0;
        end
        else if (commit && new_word[REG_MODE_HI:REG_MODE_LO] != 2'h0)
        begin
            valid_q <= 1'b0;
            wake_q <= '0;
        end
        else if (pd_exit)
        begin
            valid_q <= 1'b0;
            wake_q <= CW'(WAKE_CYCLES);
        end
        else if (wake_q != '0)
        begin
            wake_q <= wake_q - CW'(1);
            valid_q <= wake_q == CW'(1);
        end
    end

    assign dac_code = code_q;
    assign powerdown_sel_hi = mode_q[1];
    assign powerdown_sel_lo = mode_q[0];
    assign powerdown = mode_q != 2'h0;
    assign out_valid = valid_q;

    // Register bus slave: write address and data are taken together
    wire wr_go = awvalid && wvalid && !bvalid_q;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            en_q <= CTRL_EN_RST;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= awaddr == AXI_AW'(OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr == AXI_AW'(OFS_CTRL) && wstrb[0])
                en_q <= wdata[CTRL_EN_BIT];
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else if (arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            if (araddr == AXI_AW'(OFS_CTRL))
                rdata_q[CTRL_EN_BIT] <= en_q;
            else if (araddr == AXI_AW'(OFS_STAT))
            begin
                rdata_q[STAT_PD_BIT] <= powerdown;
                rdata_q[STAT_VALID_BIT] <= valid_q;
                rdata_q[STAT_HS_BIT] <= hs_q;
                rdata_q[STAT_LOCK_BIT] <= lock_q;
                rdata_q[STAT_ADDR_LO+6:STAT_ADDR_LO] <= own_addr;
            end
            else if (araddr == AXI_AW'(OFS_WORD))
                rdata_q[15:0] <= reg_q;
            else
                rresp_q <= RESP_SLVERR;
        end
        else if (rready)
            rvalid_q <= 1'b0;
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ack_addr_a: assert property ((scl_fall && st_q == S_AACK && hit_q)
        |=> !sda_oe_n) else $error("matching address not acked");
    nack_other_a: assert property ((scl_fall && st_q == S_AACK && !hit_q)
        |=> sda_oe_n) else $error("foreign address acked");
    ack_data_a: assert property ((scl_fall && st_q == S_WACK)
        |=> !sda_oe_n) else $error("write byte not acked");
    commit_word_a: assert property (commit
        |=> reg_q == {2'b00, $past(hi_q[5:0]), $past(sh_q)}
            && dac_code == reg_q[11:2]) else $error("word not committed");
    pd_enter_a: assert property ((commit && new_word[13:12] != 2'h0)
        |=> powerdown && !out_valid) else $error("power-down not entered");
    wake_hold_a: assert property (pd_exit |=> (!out_valid)[*8])
        else $error("output valid before wake-up");
    stop_idle_a: assert property (stop_det
        |=> st_q == S_IDLE && !hs_q) else $error("stop not honoured");
    start_addr_a: assert property (start_det && !stop_det
        |=> st_q == S_ADDR && bit_q == 3'h0 && $stable(hs_q))
        else $error("start not honoured");
    mcode_nack_a: assert property ((addr_last && mcode && !start_det
        && !stop_det) |=> hs_q && !hit_q) else $error("master code mishandled");
    addr_lock_a: assert property (lock_q |=> $stable(own_addr))
        else $error("locked address changed");
    read_bit_a: assert property ((scl_fall && st_q == S_RD
        && !start_det && !stop_det) |=> sda_oe_n == $past(tx_q[7]))
        else $error("read bit wrong");
    bus_resp_a: assert property (wr_go |=> bvalid)
        else $error("write response missing");

    write_pair_c: cover property (commit ##[1:1000] commit);
    read_word_c: cover property (scl_rise && st_q == S_RACK && lo_q);
    wake_done_c: cover property (pd_exit ##[1:100] out_valid);
    hs_entry_c: cover property (addr_last && mcode ##[1:500] start_det);
endmodule
`default_nettype wire

// >>> verif/dacsp_bus_master.sv
// Two-wire bus master model for the converter slave
`default_nettype none
module dacsp_bus_master (
    // Bus pins
    output var logic scl,
    output var logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock idles high between frames
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic start();
        #7;
        if (scl === 1'b0)
        begin
            #60 sda_pull = 1'b0;
            #100 scl = 1'b1;
        end
        #100 sda_pull = 1'b1;
        #100 scl = 1'b0;
    endtask

    task automatic stop();
        #50 sda_pull = 1'b1;
        #50 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask

    // Sampled late in the high phase, as a strict master would
    task automatic pulse(output logic s);
        #50 scl = 1'b1;
        #95 s = sda;
        #5 scl = 1'b0;
    endtask

    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            #50 sda_pull = ~b[i];
            pulse(s);
        end
        #50 sda_pull = 1'b0;
        pulse(s);
        ack = ~s;
    endtask

    task automatic get(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            #50 sda_pull = 1'b0;
            pulse(s);
            b[i] = s;
        end
        #50 sda_pull = more;
        pulse(s);
    endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the converter two-wire slave with power-down
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, a); end end
module tb
    import dacsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WAKE = 16;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, scl, pull, sda;
    logic sda_o, sda_oe_n, powerdown_sel_hi, powerdown_sel_lo;
    logic powerdown, out_valid, ack;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, addr_select_pin_lo, addr_select_pin_hi;
    logic [9:0] dac_code;
    logic [15:0] exp_word, w;
    logic [6:0] me, a;
    int error_cnt, n_tests;

    // Open-drain line with pull-up
    assign sda = ~pull & (sda_oe_n | sda_o);

    dacsp_top #(.WAKE_CYCLES(WAKE)) dacsp_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .addr_select_pin_lo(addr_select_pin_lo),
        .addr_select_pin_hi(addr_select_pin_hi),
        .dac_code(dac_code), .powerdown_sel_hi(powerdown_sel_hi),
        .powerdown_sel_lo(powerdown_sel_lo), .powerdown(powerdown),
        .out_valid(out_valid)
    );

    dacsp_bus_master dacsp_bus_master_i (
        .scl(scl), .sda_pull(pull), .sda(sda)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [6:0] own(logic [1:0] hi, logic [1:0] lo);
        logic [6:0] b;
        b = (hi == PIN_GND) ? BASE_HI_GND :
            (hi == PIN_SUPPLY) ? BASE_HI_SUPPLY : BASE_HI_FLOAT;
        return b + ((lo == PIN_GND) ? OFS_LO_GND :
            (lo == PIN_SUPPLY) ? OFS_LO_SUPPLY : OFS_LO_FLOAT);
    endfunction

    task automatic axw(input logic [7:0] ad, input logic [31:0] dt,
                       output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] ad, output logic [31:0] dt,
                       output logic [1:0] rs);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic addr(input logic [6:0] ad, input logic rw, input logic ex);
        dacsp_bus_master_i.start();
        dacsp_bus_master_i.put({ad, rw}, ack);
        `CHK("addr_ack", ex, ack)
    endtask

    // Bus waits here are delays, so the clock never lines up with aclk
    task automatic pair(input logic [15:0] v);
        logic was_pd;
        was_pd = |exp_word[13:12];
        dacsp_bus_master_i.put(v[15:8], ack);
        `CHK("ack_hi", 1'b1, ack)
        `CHK("early", exp_word[11:2], dac_code)
        dacsp_bus_master_i.put(v[7:0], ack);
        `CHK("ack_lo", 1'b1, ack)
        exp_word = {2'b00, v[13:0]};
        #57;
        `CHK("code", exp_word[11:2], dac_code)
        `CHK("mode", v[13:12], {powerdown_sel_hi, powerdown_sel_lo})
        `CHK("pd", |v[13:12], powerdown)
        `CHK("valid", ~|v[13:12] & ~was_pd, out_valid)
    endtask

    task automatic rdback(input logic [6:0] ad);
        logic [7:0] hi, lo;
        addr(ad, 1'b1, 1'b1);
        dacsp_bus_master_i.get(1'b1, hi);
        dacsp_bus_master_i.get(1'b0, lo);
        dacsp_bus_master_i.stop();
        `CHK("rd_word", exp_word, {hi, lo})
        axr(OFS_WORD, d, r);
        `CHK("reg_word", {16'h0000, exp_word}, d)
    endtask

    task automatic done(string s);
        $display("test %s done, %0d checks", s, n_tests);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        error_cnt = 0;
        n_tests = 0;
        exp_word = 16'h0000;
        addr_select_pin_hi = PIN_GND;
        addr_select_pin_lo = PIN_SUPPLY;
        me = own(PIN_GND, PIN_SUPPLY);
        void'($urandom(32'h1941D7D4));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        axr(OFS_WORD, d, r);
        `CHK("word_rst", 32'h0, d)
        `CHK("code_rst", 10'h000, dac_code)
        axr(OFS_STAT, d, r);
        `CHK("stat_rst", {21'h0, me, 4'h2}, d)
        axr(8'hFC, d, r);
        `CHK("rd_unmapped", {RESP_SLVERR, 32'h0}, {r, d})
        axw(8'h10, 32'hFFFF_FFFF, r);
        `CHK("wr_unmapped", RESP_SLVERR, r)
        done("reset");
        do a = 7'($urandom);
        while (a == me || a == BCAST_ADDR || a[6:2] == 5'h01);
        addr(a, 1'b0, 1'b0);
        dacsp_bus_master_i.put(8'h3F, ack);
        `CHK("ignored", 1'b0, ack)
        dacsp_bus_master_i.stop();
        axr(OFS_WORD, d, r);
        `CHK("word_kept", 32'h0, d)
        done("mismatch");
        addr(BCAST_ADDR, 1'b0, 1'b1);
        pair(16'($urandom) & 16'hCFFF);
        dacsp_bus_master_i.stop();
        axr(OFS_STAT, d, r);
        `CHK("bcast_nolock", 1'b0, d[STAT_LOCK_BIT])
        addr(BCAST_ADDR, 1'b1, 1'b0);
        dacsp_bus_master_i.stop();
        done("broadcast");
        dacsp_bus_master_i.start();
        dacsp_bus_master_i.put({5'h01, 3'($urandom)}, ack);
        `CHK("mcode_nack", 1'b0, ack)
        addr(me, 1'b0, 1'b1);
        repeat (4) pair(16'($urandom) & 16'hCFFF);
        axr(OFS_STAT, d, r);
        `CHK("hs_lock", 2'h3, d[STAT_LOCK_BIT -: 2])
        rdback(me);
        axr(OFS_STAT, d, r);
        `CHK("hs_stop", 1'b0, d[STAT_HS_BIT])
        done("write_read");
        for (int md = 1; md < 4; md++)
        begin
            w = 16'($urandom) & 16'hCFFF | 16'(md << 12);
            addr(me, 1'b0, 1'b1);
            pair(w);
            dacsp_bus_master_i.stop();
            rdback(me);
        end
        addr(me, 1'b0, 1'b1);
        pair(16'($urandom) & 16'hCFFF);
        #(25 * (WAKE - 6));
        `CHK("waking", 1'b0, out_valid)
        #200;
        `CHK("awake", 1'b1, out_valid)
        dacsp_bus_master_i.stop();
        done("powerdown");
        @(posedge aclk);
        addr_select_pin_hi <= PIN_FLOAT;
        addr_select_pin_lo <= PIN_FLOAT;
        rdback(me);
        addr(own(PIN_FLOAT, PIN_FLOAT), 1'b0, 1'b0);
        dacsp_bus_master_i.stop();
        done("lock");
        axw(OFS_CTRL, 32'h0, r);
        addr(me, 1'b0, 1'b0);
        dacsp_bus_master_i.stop();
        axw(OFS_CTRL, 32'h1, r);
        `CHK("ctrl_wr", RESP_OKAY, r)
        rdback(me);
        done("enable");
        // Mid-run reset must drop the lock and decode the new pin levels
        aresetn <= 1'b0;
        addr_select_pin_hi <= PIN_SUPPLY;
        addr_select_pin_lo <= PIN_GND;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        exp_word = REG_RST;
        me = own(PIN_SUPPLY, PIN_GND);
        repeat (6) @(posedge aclk);
        `CHK("code_rst2", 10'h000, dac_code)
        axr(OFS_STAT, d, r);
        `CHK("stat_rst2", {21'h0, me, 4'h2}, d)
        rdback(me);
        addr(own(PIN_GND, PIN_SUPPLY), 1'b0, 1'b0);
        dacsp_bus_master_i.stop();
        done("reset2");
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
